// file: afe_pkg.sv
/*
  Shared constants, types and helper functions for the host data and
  control port of a three-channel imaging front end.
  Assumes: one system clock, all users import the whole package.
*/
package afe_pkg;

  // Data path widths
  localparam int DATA_W   = 12;              // Converter result width
  localparam int CREG_W   = 8;               // Control register width
  localparam int SLOT_W   = 3;               // Slice slot counter width
  localparam int SER_W    = 3;               // Serial bit counter width
  localparam int AHB_DW   = 32;              // Bus data width
  localparam int AHB_DEC  = 8;               // Decoded address bits
  localparam int UPPER_LO = 4;               // Lowest line of the control byte

  // Bus register offsets and fields
  localparam logic [AHB_DEC-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [AHB_DEC-1:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_W       = 3;           // Mode[1:0], single-channel[2]
  localparam int CTRL_LBL_BIT = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  localparam logic [CREG_W-1:0] CREG_RESET = 8'h00;

  // Serial frame: eight address bits then eight data bits
  localparam logic [SER_W-1:0] SER_LAST = 3'h7;
  localparam int SER_READ_BIT = 7;           // Address MSB flags a read

  // Synchronised pin positions
  localparam int PIN_N     = 7;
  localparam int PIN_RST   = 0;
  localparam int PIN_OD    = 1;
  localparam int PIN_EN    = 2;
  localparam int PIN_DNA   = 3;
  localparam int PIN_RNW   = 4;
  localparam int PIN_CLAMP = 5;
  localparam int PIN_VSP   = 6;
  // Chip reset pin idles high: a low reset value would fake a release
  localparam logic [PIN_N-1:0] PIN_RESET = 7'h01;

  // Output formats
  typedef enum logic [1:0] {
    OUT_FULL12 = 2'b00,
    OUT_MUX8   = 2'b01,
    OUT_MUX6   = 2'b10,
    OUT_MUX4   = 2'b11
  } afe_out_mode_t;

  // Input channels; code 2'b11 is illegal
  typedef enum logic [1:0] {
    CH_RED   = 2'b00,
    CH_GREEN = 2'b01,
    CH_BLUE  = 2'b10
  } afe_chan_t;

  // Serial interface phases
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_ADDR = 2'b01,
    SER_DATA = 2'b10
  } afe_ser_t;

  // Slices per result
  function automatic logic [SLOT_W-1:0] slotCount(afe_out_mode_t m);
    unique case (m)
      OUT_FULL12: slotCount = 3'h1;
      OUT_MUX8:   slotCount = 3'h2;
      OUT_MUX6:   slotCount = 3'h2;
      OUT_MUX4:   slotCount = 3'h4;
    endcase
  endfunction

  // Lines used by one slice
  function automatic logic [3:0] sliceShift(afe_out_mode_t m);
    unique case (m)
      OUT_FULL12: sliceShift = 4'hC;
      OUT_MUX8:   sliceShift = 4'h8;
      OUT_MUX6:   sliceShift = 4'h6;
      OUT_MUX4:   sliceShift = 4'h4;
    endcase
  endfunction

  // Bus lines carrying a slice
  function automatic logic [DATA_W-1:0] sliceMask(afe_out_mode_t m);
    unique case (m)
      OUT_FULL12: sliceMask = 12'hFFF;
      OUT_MUX8:   sliceMask = 12'hFF0;
      OUT_MUX6:   sliceMask = 12'hFC0;
      OUT_MUX4:   sliceMask = 12'hF00;
    endcase
  endfunction

  // Red, green, blue rotation
  function automatic afe_chan_t nextChannel(afe_chan_t c);
    unique case (c)
      CH_RED:   nextChannel = CH_GREEN;
      CH_GREEN: nextChannel = CH_BLUE;
      CH_BLUE:  nextChannel = CH_RED;
      default:  nextChannel = CH_RED;
    endcase
  endfunction

endpackage

// file: afe_slice_if.sv
/*
  Carrier between the port logic and the slice serialiser.
  Assumes: both ends on clk_sys.
*/
`timescale 1ns/10ps
interface afe_slice_if;
  import afe_pkg::*;
  logic [DATA_W-1:0] word;        // Converter result
  logic              wordValid;   // Result strobe
  afe_out_mode_t     mode;        // Output format
  logic [DATA_W-1:0] slice;       // Slice aligned to the top lines
  logic              sliceValid;  // Slice present
  logic              busy;        // Slices still pending
  modport port (output word, wordValid, mode, input slice, sliceValid, busy);
  modport slicer (input word, wordValid, mode, output slice, sliceValid, busy);
endinterface

// file: afe_slicer.sv
/*
  Splits each converter result into bus slices, most significant first.
  Assumes: results arrive no faster than one per slice sequence;
  a result offered while busy is dropped.
*/
`timescale 1ns/10ps
module afe_slicer import afe_pkg::*; (
  // Clock and control
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Result in, slices out
  afe_slice_if.slicer sl
);
  logic [DATA_W-1:0] shift_q;       // Bits not yet sent, top aligned
  logic [SLOT_W-1:0] left_q;        // Slices still to send
  logic [DATA_W-1:0] slice_q;       // Current slice
  logic              sliceValid_q;  // Slice strobe
  afe_out_mode_t     mode_q;        // Format of the result in flight
  wire               accept = sl.wordValid && (left_q == '0);

  assign sl.slice      = slice_q;
  assign sl.sliceValid = sliceValid_q;
  assign sl.busy       = (left_q != '0);

  // Load a result or step to the next slice
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_q      <= '0;
      left_q       <= '0;
      slice_q      <= '0;
      sliceValid_q <= 1'b0;
      mode_q       <= OUT_FULL12;
    end else if (ce) begin
      if (accept) begin // MSB slice first
        slice_q      <= sl.word & sliceMask(sl.mode);
        shift_q      <= sl.word << sliceShift(sl.mode);
        left_q       <= slotCount(sl.mode) - 3'h1;
        mode_q       <= sl.mode;
        sliceValid_q <= 1'b1;
      end else if (left_q != '0) begin // Lower slices follow
        slice_q      <= shift_q & sliceMask(mode_q);
        shift_q      <= shift_q << sliceShift(mode_q);
        left_q       <= left_q - 3'h1;
        sliceValid_q <= 1'b1;
      end else begin
        sliceValid_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !ce);

  a_full_one_slice: assert property (accept && sl.mode == OUT_FULL12 |=>
    sliceValid_q && slice_q == $past(sl.word) ##1 (!sliceValid_q || $past(accept)))
    else $error("full-width result not sent whole");
  a_mux8_two_slots: assert property (accept && sl.mode == OUT_MUX8 |=>
    sliceValid_q ##1 sliceValid_q && slice_q[11:8] == $past(sl.word[3:0], 2))
    else $error("eight-bit slices wrong");
  a_mux6_two_slots: assert property (accept && sl.mode == OUT_MUX6 |=>
    slice_q[11:6] == $past(sl.word[11:6]) ##1 slice_q[11:6] == $past(sl.word[5:0], 2))
    else $error("six-bit slices wrong");
  a_mux4_four_slots: assert property (accept && sl.mode == OUT_MUX4 |=>
    sliceValid_q [*4] ##0 slice_q == 12'h000)
    else $error("four-bit sequence wrong");
  a_msb_first_order: assert property (accept && sl.mode == OUT_MUX8 |=>
    slice_q[11:4] == $past(sl.word[11:4]) && slice_q[3:0] == 4'h0)
    else $error("first slice is not the top bits");
  c_mux4_run: cover property (accept && sl.mode == OUT_MUX4 ##4 accept);
endmodule // afe_slicer

// file: afe_host_port.sv
/*
  Host data and control port: pixel bus formatting, parallel and serial
  control register access, channel sequencing and an AHB-Lite slave.
  Assumes: every pin input is asynchronous to clk_sys; the converter
  result and its strobe are on clk_sys; the bus master makes single
  word transfers only.
*/
`timescale 1ns/10ps
module afe_host_port import afe_pkg::*; #(
  parameter int CREG_COUNT = 8            // Control registers behind the pins
) (
  // Clock, reset, enable
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                ce,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [AHB_DW-1:0]   haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [AHB_DW-1:0]   hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic      [AHB_DW-1:0]   hrdata,
  // Control pins from the scanner controller
  input  wire logic                chipResetLow,
  input  wire logic                outputDisable,
  input  wire logic                enableOrStrobe,
  input  wire logic                serialInOrDataSelect,
  input  wire logic                serialClockOrReadSelect,
  input  wire logic                clampOrAutocycle,
  input  wire logic                videoSamplePulse,
  // Pixel bus, split into its three parts
  input  wire logic [DATA_W-1:0]   pixelBusIn,
  output logic      [DATA_W-1:0]   pixelBusOut,
  output logic      [DATA_W-1:0]   pixelBusOe,
  // Converter side
  input  wire logic [DATA_W-1:0]   adcResult,
  input  wire logic                adcValid,
  output logic                     sampleStrobe,
  output logic      [1:0]          channelSel,
  output logic                     clampActive
);
  localparam int IDX_W = $clog2(CREG_COUNT);   // Register index width

  // Pin synchronisers, first stage read only by the second
  logic [PIN_N-1:0]    pinMeta_q, pinSync_q, pinPrev_q;
  logic [CREG_W-1:0]   busMeta_q, busSync_q;   // Lines 11..4 in
  // Control register file and access state
  logic [CREG_W-1:0]   creg_q [CREG_COUNT];
  logic [CREG_W-1:0]   cregAddr_q;             // Current register address
  logic                parallelSel_q;          // Interface picked at reset
  afe_ser_t            serState_q;             // Serial phase
  logic [SER_W-1:0]    serCnt_q;               // Bits of this phase
  logic [CREG_W-1:0]   serShift_q;             // Serial bits so far
  // Bus registers and answer
  logic [CTRL_W-1:0]   ctrl_q, ctrl_d;
  logic                dValid_q, dWrite_q;     // Pending data phase
  logic [AHB_DEC-1:0]  dAddr_q;
  logic [AHB_DW-1:0]   hrdata_q;
  logic                hreadyout_q, hresp_q;
  // Output flops
  logic [DATA_W-1:0]   pixOut_q, pixOe_q, pixOut_d, pixOe_d;
  logic                sampleStrobe_q, clampActive_q;
  afe_chan_t           chan_q;

  afe_slice_if sl ();

  // Named pin views
  wire rstPin  = pinSync_q[PIN_RST];
  wire odPin   = pinSync_q[PIN_OD];
  wire enPin   = pinSync_q[PIN_EN];
  wire dnaPin  = pinSync_q[PIN_DNA];
  wire rnwPin  = pinSync_q[PIN_RNW];
  wire clmpPin = pinSync_q[PIN_CLAMP];
  wire resetRise = rstPin && !pinPrev_q[PIN_RST];
  wire stbFall   = !enPin && pinPrev_q[PIN_EN];
  wire enRise    = enPin && !pinPrev_q[PIN_EN];
  wire sclkRise  = rnwPin && !pinPrev_q[PIN_RNW];
  wire clmpRise  = clmpPin && !pinPrev_q[PIN_CLAMP];
  wire vspRise   = pinSync_q[PIN_VSP] && !pinPrev_q[PIN_VSP];
  wire singleCh  = ctrl_q[CTRL_LBL_BIT];
  afe_out_mode_t outMode;
  assign outMode = afe_out_mode_t'(ctrl_q[1:0]);
  wire [DATA_W-1:0] curMask = sliceMask(outMode);   // Lines of the current format

  // Register decoding
  wire [IDX_W-1:0]  cregIdx  = cregAddr_q[IDX_W-1:0];
  wire [CREG_W-1:0] cregRd   = creg_q[cregIdx];
  wire              serRead  = cregAddr_q[SER_READ_BIT];
  wire              parWrite = parallelSel_q && stbFall && !rnwPin;
  wire              serStep  = !parallelSel_q && enPin && sclkRise;
  wire              serDone  = serStep && serState_q == SER_DATA && serCnt_q == SER_LAST;
  wire              parRead  = parallelSel_q && rnwPin && !enPin;
  wire              serOut   = (serState_q == SER_DATA) && serRead
                               && cregRd[SER_LAST - serCnt_q];
  wire              addrTake = hsel && htrans[1] && hready;
  wire              ctrlWr   = dValid_q && dWrite_q && dAddr_q == ADDR_CTRL;
  wire [AHB_DW-1:0] statusWord = {{(AHB_DW - 5){1'b0}}, sl.busy, odPin,
                                  chan_q, parallelSel_q};

  // Control written in the data phase, forwarded to a following read
  assign ctrl_d = ctrlWr ? hwdata[CTRL_W-1:0] : ctrl_q;

  // Slicer hookup
  assign sl.word      = adcResult;
  assign sl.wordValid = adcValid;
  assign sl.mode      = outMode;

  afe_slicer u_slicer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .sl      (sl)
  );

  // Two-stage capture of every control pin and of bus lines 11..4
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinMeta_q <= PIN_RESET;
      pinSync_q <= PIN_RESET;
      pinPrev_q <= PIN_RESET;
      busMeta_q <= CREG_RESET;
      busSync_q <= CREG_RESET;
    end else if (ce) begin
      pinMeta_q <= {videoSamplePulse, clampOrAutocycle, serialClockOrReadSelect,
                    serialInOrDataSelect, enableOrStrobe, outputDisable, chipResetLow};
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
      busMeta_q <= pixelBusIn[DATA_W-1:UPPER_LO];
      busSync_q <= busMeta_q;
    end
  end

  // Interface choice caught as the chip reset releases
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) parallelSel_q <= 1'b0;
    else if (ce && resetRise) parallelSel_q <= enPin;
  end

  // Control register file, parallel and serial writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CREG_COUNT; i++) creg_q[i] <= CREG_RESET;
      cregAddr_q <= CREG_RESET;
    end else if (ce) begin
      if (!rstPin) begin // Pin reset clears every register and the address
        for (int i = 0; i < CREG_COUNT; i++) creg_q[i] <= CREG_RESET;
        cregAddr_q <= CREG_RESET;
      end else if (parWrite && !dnaPin) begin
        cregAddr_q <= busSync_q;
      end else if (parWrite) begin
        creg_q[cregIdx] <= busSync_q;
      end else if (serStep && serState_q == SER_ADDR && serCnt_q == SER_LAST) begin
        cregAddr_q <= {serShift_q[CREG_W-2:0], dnaPin};
      end else if (serDone && !serRead) begin
        creg_q[cregIdx] <= {serShift_q[CREG_W-2:0], dnaPin};
      end
    end
  end

  // Serial frame sequencing, restarted by each enable pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      serState_q <= SER_IDLE;
      serCnt_q   <= '0;
      serShift_q <= CREG_RESET;
    end else if (ce) begin
      if (!rstPin || parallelSel_q || !enPin) begin
        serState_q <= SER_IDLE;
        serCnt_q   <= '0;
      end else if (enRise) begin
        serState_q <= SER_ADDR;
        serCnt_q   <= '0;
      end else if (serStep && serState_q != SER_IDLE) begin
        serShift_q <= {serShift_q[CREG_W-2:0], dnaPin};
        serCnt_q   <= serCnt_q + 3'h1;
        if (serCnt_q == SER_LAST) begin
          serState_q <= (serState_q == SER_ADDR) ? SER_DATA : SER_IDLE;
        end
      end
    end
  end

  // Pixel bus drive and direction
  always_comb begin
    pixOut_d = sl.slice;
    pixOe_d  = sl.sliceValid ? curMask : pixOe_q;
    if (parallelSel_q && !rnwPin) begin // Host drives the upper lines
      pixOe_d[DATA_W-1:UPPER_LO] = '0;
    end else if (parRead) begin // Register readback on lines 11..4
      pixOut_d[DATA_W-1:UPPER_LO] = cregRd;
      pixOe_d[DATA_W-1:UPPER_LO]  = '1;
    end else if (!parallelSel_q && enPin) begin // Serial readback line
      pixOut_d[DATA_W-1] = serOut;
      pixOe_d[DATA_W-1]  = 1'b1;
    end
    if (!parallelSel_q && !enPin && !sl.sliceValid) begin
      pixOe_d[DATA_W-1] = pixOe_q[DATA_W-1] && curMask[DATA_W-1];
    end
    if (odPin) pixOe_d = '0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pixOut_q <= '0;
      pixOe_q  <= '0;
    end else if (ce) begin
      pixOut_q <= pixOut_d;
      pixOe_q  <= pixOe_d;
    end
  end

  // Sampling, clamping and channel rotation
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sampleStrobe_q <= 1'b0;
      clampActive_q  <= 1'b0;
      chan_q         <= CH_RED;
    end else if (ce) begin
      sampleStrobe_q <= vspRise;
      clampActive_q  <= clmpPin && !singleCh;
      if (singleCh && clmpRise) chan_q <= nextChannel(chan_q);
      else if (!singleCh && vspRise) chan_q <= nextChannel(chan_q);
    end
  end

  // Bus slave: capture address phase, act in data phase
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dValid_q    <= 1'b0;
      dWrite_q    <= 1'b0;
      dAddr_q     <= '0;
      hrdata_q    <= '0;
      ctrl_q      <= CTRL_RESET;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else if (ce) begin
      ctrl_q   <= ctrl_d;
      dValid_q <= addrTake;
      if (addrTake) begin
        dWrite_q <= hwrite;
        dAddr_q  <= haddr[AHB_DEC-1:0];
        if (haddr[AHB_DEC-1:0] == ADDR_CTRL)
          hrdata_q <= {{(AHB_DW - CTRL_W){1'b0}}, ctrl_d};
        else if (haddr[AHB_DEC-1:0] == ADDR_STATUS)
          hrdata_q <= statusWord;
        else
          hrdata_q <= '0; // Unmapped reads zero
      end
    end
  end

  assign hreadyout    = hreadyout_q;
  assign hresp        = hresp_q;
  assign hrdata       = hrdata_q;
  assign pixelBusOut  = pixOut_q;
  assign pixelBusOe   = pixOe_q;
  assign sampleStrobe = sampleStrobe_q;
  assign channelSel   = chan_q;
  assign clampActive  = clampActive_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !ce);

  a_disable_floats_bus: assert property (odPin |=> pixelBusOe == '0)
    else $error("bus driven while disabled");
  a_parallel_write_lands: assert property (parWrite && dnaPin && rstPin |=>
    creg_q[$past(cregIdx)] == $past(busSync_q))
    else $error("parallel write lost");
  a_parallel_readback: assert property (parRead && !odPin |=>
    pixelBusOut[11:4] == $past(cregRd) && pixelBusOe[11:4] == 8'hFF)
    else $error("readback not driven");
  a_pin_reset_clears: assert property (!rstPin |=>
    creg_q[0] == CREG_RESET && cregAddr_q == CREG_RESET)
    else $error("pin reset left state");
  a_interface_latch: assert property (resetRise |=> parallelSel_q == $past(enPin))
    else $error("interface choice not caught");
  a_read_select_release: assert property (parallelSel_q && !rnwPin |=>
    pixelBusOe[11:4] == 8'h00)
    else $error("lines 11..4 driven during host write");
  a_clamp_gate: assert property (!clmpPin |=> !clampActive_q)
    else $error("clamp without request");
  a_auto_cycle: assert property (singleCh && clmpRise |=>
    chan_q == nextChannel($past(chan_q)))
    else $error("auto cycle missed a step");
  a_sample_pulse: assert property (vspRise |=> sampleStrobe_q ##1 !sampleStrobe_q)
    else $error("sample strobe misaligned");
  a_three_channel_rot: assert property (!singleCh && vspRise |=>
    chan_q == nextChannel($past(chan_q)))
    else $error("channel rotation stuck");
  a_serial_line_held: assert property (!parallelSel_q && enPin && !odPin |=>
    pixelBusOe[11])
    else $error("serial readback line floated");
  c_parallel_write: cover property (parWrite && dnaPin);
  c_serial_read: cover property (serDone && serRead);
  c_ctrl_write: cover property (ctrlWr);
endmodule // afe_host_port

// file: afe_scan_model.sv
/*
  Scanner controller model: drives the control pins and the host side
  of the shared pixel bus of the host port.
  Assumes: the bench calls its tasks; it shares clk_sys with the port.
*/
`timescale 1ns/10ps
module afe_scan_model import afe_pkg::*; (
  // Clock
  input  wire logic              clk_sys,
  // Port drive of the pixel bus
  input  wire logic [DATA_W-1:0] busOut,
  input  wire logic [DATA_W-1:0] busOe,
  // Pins towards the port
  output logic                   chipResetLow,
  output logic                   outputDisable,
  output logic                   enableOrStrobe,
  output logic                   serialInOrDataSelect,
  output logic                   serialClockOrReadSelect,
  output logic                   clampOrAutocycle,
  output logic                   videoSamplePulse,
  output logic [DATA_W-1:0]      busIn
);
  logic              hostOe;   // Host drives lines 11..4
  logic [DATA_W-1:0] hostVal;  // Host drive value

  // Undriven lines show the inverse, so stale data never passes
  assign busIn = (busOe & busOut) | (~busOe & (hostOe ? hostVal : ~hostVal));

  // Pin levels at time zero; chip reset held low
  initial begin
    {outputDisable, serialInOrDataSelect, serialClockOrReadSelect} = 3'h0;
    {clampOrAutocycle, videoSamplePulse, hostOe} = 3'h0;
    {chipResetLow, enableOrStrobe} = 2'h0;
    hostVal = 12'h000;
  end

  // Wait a number of clock edges
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Chip reset; interface level held well across the release
  task automatic chipReset(input logic par);
    chipResetLow <= 1'b0;
    enableOrStrobe <= par;
    waitClk(6);
    chipResetLow <= 1'b1;
    waitClk(6);
  endtask

  // One strobe cycle; the port's drive is captured while strobe is low
  task automatic parCycle(input logic dna, input logic rnw, input logic [7:0] v,
                          output logic [DATA_W-1:0] so, output logic [DATA_W-1:0] se);
    serialInOrDataSelect <= dna;
    serialClockOrReadSelect <= rnw;
    hostOe <= !rnw;
    hostVal <= {v, 4'h0};
    waitClk(1);
    enableOrStrobe <= 1'b0;
    waitClk(6);
    so = busOut;
    se = busOe;
    enableOrStrobe <= 1'b1;
    // Data held past the strobe edge for the port's synchronisers
    waitClk(5);
    hostOe <= 1'b0;
    waitClk(1);
  endtask

  // One pixel marker
  task automatic vsp();
    videoSamplePulse <= 1'b1;
    waitClk(3);
    videoSamplePulse <= 1'b0;
    waitClk(5); // Eight clocks per pixel
  endtask

  // One serial frame, MSB first; line 11 caught during the data bits
  task automatic serFrame(input logic [15:0] f, output logic [7:0] rb);
    enableOrStrobe <= 1'b1;
    waitClk(4);
    for (int i = 15; i >= 0; i--) begin
      serialInOrDataSelect <= f[i];
      waitClk(4);
      if (i < 8) rb[i] = busOut[DATA_W-1];
      serialClockOrReadSelect <= 1'b1;
      waitClk(4);
      serialClockOrReadSelect <= 1'b0;
    end
    waitClk(4);
    enableOrStrobe <= 1'b0;
    waitClk(4);
  endtask
endmodule // afe_scan_model

// file: tb_top.sv
/*
  Self-checking bench of the host port: bus registers, pixel slicing,
  output disable, parallel control access and channel stepping.
  Assumes: the scanner model drives every pin; ce dropped once only.
*/
`timescale 1ns/10ps
module tb_top import afe_pkg::*;;
  logic              clk_sys, rst, hwrite, adcValid;  // Bench drives
  logic              ce, hsel;                        // Enable, select
  logic [2:0]        hsize;                           // Transfer size
  logic [1:0]        htrans;                          // Transfer type
  logic [AHB_DW-1:0] haddr, hwdata, hrdata, rd;       // Bus words
  logic [DATA_W-1:0] adcResult, busIn, busOut, busOe; // Pixel side
  logic [DATA_W-1:0] sOut, sOe;                       // Captured drive
  logic              hreadyout, hresp, sampleStrobe, clampActive;
  logic [1:0]        channelSel;                      // Channel code
  logic              nRst, od, eos, dna, rnw, clampPin, vsp;
  logic [31:0]       seed;                            // Xorshift state
  int                errCount, cmpCount, nStrobe;     // Tallies
  int                q[$];                            // Expected slices

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;
  // Pixel markers seen at the port
  always @(negedge clk_sys) if (sampleStrobe === 1'b1) nStrobe++;

  afe_host_port #(.CREG_COUNT(8)) DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .chipResetLow(nRst), .outputDisable(od), .enableOrStrobe(eos),
    .serialInOrDataSelect(dna), .serialClockOrReadSelect(rnw),
    .clampOrAutocycle(clampPin), .videoSamplePulse(vsp), .pixelBusIn(busIn),
    .pixelBusOut(busOut), .pixelBusOe(busOe), .adcResult(adcResult),
    .adcValid(adcValid), .sampleStrobe(sampleStrobe), .channelSel(channelSel),
    .clampActive(clampActive));

  afe_scan_model pm (.clk_sys(clk_sys), .busOut(busOut), .busOe(busOe),
    .chipResetLow(nRst), .outputDisable(od), .enableOrStrobe(eos),
    .serialInOrDataSelect(dna), .serialClockOrReadSelect(rnw),
    .clampOrAutocycle(clampPin), .videoSamplePulse(vsp), .busIn(busIn));

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Compare and tally
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmpCount++;
    if (g !== e) begin
      errCount++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  // One single-word transfer; read data kept in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // One result in mode m; slices predicted with integers
  task automatic sendWord(input int m);
    int sh, n, w, mask;
    sh = (m == 0) ? 12 : (m == 1) ? 8 : (m == 2) ? 6 : 4;
    n = (m == 0) ? 1 : (m == 3) ? 4 : 2;
    mask = (4095 << (12 - sh)) & 4095;
    w = rnd() & 4095;
    for (int k = 0; k < n; k++) q.push_back((w << (k * sh)) & mask);
    @(posedge clk_sys);
    adcResult <= w[11:0];
    adcValid <= 1'b1;
    @(posedge clk_sys);
    adcValid <= 1'b0;
    @(posedge clk_sys);
    while (q.size() > 0) begin
      @(negedge clk_sys);
      chk(busOut, q.pop_front());
      chk(busOe, mask);
    end
  endtask

  // Verdict and end of run
  task automatic finalReport();
    if (errCount == 0 && cmpCount > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #400_000; // 20,000 cycles, far beyond the run
    errCount++;
    finalReport();
  end

  // Main sequence
  initial begin
    {clk_sys, hwrite, adcValid, htrans, haddr, hwdata, adcResult, hsel, hsize} = '0;
    ce = 1'b1;
    {errCount, cmpCount, nStrobe} = '0;
    rst = 1'b1;
    seed = 32'd66;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    pm.chipReset(1'b0);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    chk({hresp, rd[0]}, 2'h0);
    // Serial write, then serial read of the same register
    rd = rnd();
    pm.serFrame({8'h05, rd[7:0]}, sOut[7:0]);
    pm.serFrame(16'h8500, sOut[7:0]);
    chk(sOut[7:0], rd[7:0]);
    ahb(1'b1, 8'h40, rnd());
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    // Three-channel stepping per marker
    for (int i = 1; i <= 3; i++) begin
      pm.vsp();
      chk(channelSel, i % 3);
    end
    // Clock enable low: the marker is lost and nothing moves
    ce <= 1'b0;
    pm.vsp();
    ce <= 1'b1;
    chk(channelSel, 2'h0);
    chk(nStrobe, 3);
    pm.clampOrAutocycle <= 1'b1;
    pm.waitClk(6);
    chk(clampActive, 1'b1);
    pm.clampOrAutocycle <= 1'b0;
    pm.waitClk(6);
    chk(clampActive, 1'b0);
    // Single-channel: clamp pin steps the channel, no clamping
    ahb(1'b1, ADDR_CTRL, 32'h4);
    pm.clampOrAutocycle <= 1'b1;
    pm.waitClk(6);
    chk(channelSel, 2'h1);
    chk(clampActive, 1'b0);
    pm.clampOrAutocycle <= 1'b0;
    // Every output format
    for (int m = 0; m < 4; m++) begin
      ahb(1'b1, ADDR_CTRL, m);
      sendWord(m);
    end
    pm.outputDisable <= 1'b1;
    pm.waitClk(5);
    chk(busOe, 12'h000);
    pm.outputDisable <= 1'b0;
    // Parallel control: address, data, readback, chip reset
    pm.chipReset(1'b1);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    pm.parCycle(1'b0, 1'b0, 8'h03, sOut, sOe);
    chk(sOe[11:4], 8'h00);
    rd = rnd();
    pm.parCycle(1'b1, 1'b0, rd[7:0], sOut, sOe);
    pm.parCycle(1'b1, 1'b1, 8'h00, sOut, sOe);
    chk(sOut[11:4], rd[7:0]);
    chk(sOe[11:4], 8'hFF);
    pm.chipReset(1'b1);
    pm.parCycle(1'b0, 1'b0, 8'h03, sOut, sOe);
    pm.parCycle(1'b1, 1'b1, 8'h00, sOut, sOe);
    chk(sOut[11:4], 8'h00);
    // System reset with the pins idle high: serial again, no false release
    rst <= 1'b1;
    pm.waitClk(2);
    rst <= 1'b0;
    ahb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[0], 1'b0);
    finalReport();
  end
endmodule // tb_top
